// [verilog/ssm_pkg.sv]
// Notes on behaviour
// - subtract stores first minus second, fraction only
// - magnitude at least one raises capacity exceeded
// - stored sign follows untruncated difference sign
// - first execute holds first operand, word recirculates
// - second execute forms difference within one cycle
// - fourth execute delivers next order word
// - compare reuses subtract, sends result to dispatcher
// - dispatcher picks third on minus, else fourth
// - compare leaves memory unchanged, recirculates next order
// - compare final execute waits two minor cycles
// - multiply loads two tanks, runs 43 cycles
// - multiply never raises capacity exceeded
// - round product at digit 44, drop 44-86
// - round carry injected on final pass
// - zero rounded product gets plus sign
// - multiply store no earlier than 43 cycles
// - both zeros decode as zero, encode plus except on capacity exceeded
package ssm_pkg;
    localparam int DIG_W = 43;
    localparam int WORD_W = 44;
    localparam int SIGN_POS = 43;
    localparam int MUL_CYCLES = 43;
    localparam int CMP_GAP = 2;
    localparam logic [5:0] MUL_CNT_INIT = 6'h2B;
    localparam logic [1:0] CMP_GAP_CNT = 2'h2;
    typedef enum logic [1:0] {
        SSM_OP_SUB = 2'h0,
        SSM_OP_CMP = 2'h1,
        SSM_OP_MUL = 2'h2,
        SSM_OP_NONE = 2'h3
    } ssm_op_e;
endpackage

// [verilog/ssm_if.sv]
`timescale 1ns/1ps
// link between dispatcher end and arithmetic unit end
interface ssm_if;
    logic [1:0] op;
    logic [2:0] exec_sel;
    logic exec_stb;
    logic [43:0] mem_word;
    logic [43:0] store_word;
    logic store_vld;
    logic [43:0] recirc_word;
    logic [43:0] next_order;
    logic next_order_vld;
    logic cap_exceeded;
    logic cmp_sign;
    logic cmp_vld;
    logic busy;
    modport unit (input op, exec_sel, exec_stb, mem_word, output store_word, store_vld, recirc_word,
        next_order, next_order_vld, cap_exceeded, cmp_sign, cmp_vld, busy);
    modport disp (output op, exec_sel, exec_stb, mem_word, input store_word, store_vld, recirc_word,
        next_order, next_order_vld, cap_exceeded, cmp_sign, cmp_vld, busy);
endinterface

// [verilog/ssm_unit.sv]
`timescale 1ns/1ps
// arithmetic unit: subtract, compare, multiply with round-off
module ssm_unit (
    input wire logic clk_in,
    input wire logic rst_n_in,
    ssm_if.unit link,
    output logic busy_out
);
    import ssm_pkg::*;
    typedef struct packed {
        logic [43:0] tank1;
        logic [43:0] tank2;
        logic [43:0] result;
        logic [42:0] acc;
        logic [42:0] mplier;
        logic [5:0] cnt;
        logic [1:0] op;
        logic [43:0] store_word;
        logic store_vld;
        logic [43:0] recirc_word;
        logic [43:0] next_order;
        logic next_order_vld;
        logic cap_exceeded;
        logic cmp_sign;
        logic cmp_vld;
        logic busy;
    } ssm_unit_s;
    ssm_unit_s st_r, st_nxt;
    logic [44:0] diff_mag;
    logic diff_neg;
    logic [43:0] addend;
    logic [43:0] sum;
    logic [42:0] prod_mag;
    always_comb begin
        diff_mag = '0;
        diff_neg = 1'b0;
        if (st_r.tank1[SIGN_POS] == link.mem_word[SIGN_POS]) begin // operands like-signed: subtract magnitudes
            if (st_r.tank1[42:0] >= link.mem_word[42:0]) begin
                diff_mag = {2'h0, st_r.tank1[42:0] - link.mem_word[42:0]};
                diff_neg = st_r.tank1[SIGN_POS] && (diff_mag != '0);
            end else begin
                diff_mag = {2'h0, link.mem_word[42:0] - st_r.tank1[42:0]};
                diff_neg = !st_r.tank1[SIGN_POS];
            end
        end else begin
            diff_mag = {2'h0, st_r.tank1[42:0]} + {2'h0, link.mem_word[42:0]};
            diff_neg = st_r.tank1[SIGN_POS] && (diff_mag != '0); // -0 minus +0 still gives +0
        end
    end
    // one serial step: add multiplicand if multiplier bit set; last step adds round carry
    always_comb begin
        addend = st_r.mplier[0] ? {1'b0, st_r.tank2[42:0]} : 44'h0;
        sum = {1'b0, st_r.acc} + addend + {43'h0, (st_r.cnt == 6'h01)};
        prod_mag = st_r.acc;
    end
    always_comb begin
        st_nxt = st_r;
        st_nxt.store_vld = 1'b0;
        st_nxt.next_order_vld = 1'b0;
        st_nxt.cmp_vld = 1'b0;
        if (st_r.cnt != 6'h00) begin
            // shift right keeps high half; low half drops, so the round carry at the
            // final pass lands as one half unit of digit 43
            st_nxt.acc = sum[43:1];
            st_nxt.mplier = {1'b0, st_r.mplier[42:1]};
            st_nxt.cnt = st_r.cnt - 6'h01;
            if (st_r.cnt == 6'h01) begin
                st_nxt.busy = 1'b0;
            end
        end
        if (link.exec_stb) begin
            st_nxt.recirc_word = link.mem_word;
            case (link.exec_sel)
                3'h1: begin
                    st_nxt.op = link.op;
                    st_nxt.tank1 = link.mem_word;
                    st_nxt.cap_exceeded = 1'b0;
                end
                3'h2: begin
                    if (st_r.op == SSM_OP_MUL) begin
                        st_nxt.tank2 = st_r.tank1;
                        st_nxt.tank1 = link.mem_word;
                        st_nxt.mplier = link.mem_word[42:0]; // digits only, sign stays in tank1
                        st_nxt.acc = '0;
                        st_nxt.cnt = MUL_CNT_INIT;
                        st_nxt.busy = 1'b1;
                        st_nxt.cap_exceeded = 1'b0;
                    end else begin
                        st_nxt.result = {diff_neg, diff_mag[42:0]};
                        st_nxt.cap_exceeded = (st_r.op == SSM_OP_SUB) && diff_mag[43];
                        if (st_r.op == SSM_OP_CMP) begin
                            st_nxt.cmp_sign = diff_neg;
                            st_nxt.cmp_vld = 1'b1;
                        end
                    end
                end
                3'h3: begin
                    if (st_r.op == SSM_OP_MUL) begin
                        st_nxt.store_word = {(st_r.tank1[SIGN_POS] ^ st_r.tank2[SIGN_POS]) && (prod_mag != '0),
                            prod_mag};
                        st_nxt.store_vld = !st_r.busy;
                    end else if (st_r.op == SSM_OP_SUB) begin
                        st_nxt.store_word = st_r.result;
                        st_nxt.store_vld = 1'b1;
                    end else begin
                        st_nxt.next_order = link.mem_word;
                        st_nxt.next_order_vld = 1'b1;
                    end
                end
                3'h4: begin
                    st_nxt.next_order = link.mem_word;
                    st_nxt.next_order_vld = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign link.store_word = st_r.store_word;
    assign link.store_vld = st_r.store_vld;
    assign link.recirc_word = st_r.recirc_word;
    assign link.next_order = st_r.next_order;
    assign link.next_order_vld = st_r.next_order_vld;
    assign link.cap_exceeded = st_r.cap_exceeded;
    assign link.cmp_sign = st_r.cmp_sign;
    assign link.cmp_vld = st_r.cmp_vld;
    assign link.busy = st_r.busy;
    assign busy_out = st_r.busy;
endmodule

// [verilog/ssm_disp.sv]
`timescale 1ns/1ps
// dispatcher end: sequences the executes of one order
module ssm_disp (
    input wire logic clk_in,
    input wire logic rst_n_in,
    ssm_if.disp link,
    input wire logic start_in,
    input wire logic [1:0] op_in,
    input wire logic [43:0] word_in,
    output logic [2:0] addr_sel_out,
    output logic exec_pending_out,
    output logic [43:0] next_order_out,
    output logic next_order_vld_out,
    output logic cap_exceeded_out
);
    import ssm_pkg::*;
    typedef struct packed {
        logic [1:0] op;
        logic [2:0] step;
        logic [5:0] wait_cnt;
        logic [43:0] next_order;
        logic next_order_vld;
        logic cap;
        logic cmp_sign;
        logic active;
        logic [2:0] addr_sel;
    } ssm_disp_s;
    ssm_disp_s st_r, st_nxt;
    logic go;
    // an execute issues when wait has elapsed and the unit is idle; word_in must hold the addressed word
    always_comb begin
        st_nxt = st_r;
        st_nxt.next_order_vld = 1'b0;
        go = st_r.active && (st_r.wait_cnt == 6'h00) && !link.busy;
        if (st_r.wait_cnt != 6'h00) begin
            st_nxt.wait_cnt = st_r.wait_cnt - 6'h01;
        end
        if (link.cmp_vld) begin
            st_nxt.cmp_sign = link.cmp_sign;
        end
        // the unit holds its flag until exec 1 of the next order, so a stale flag is ignored until then
        if (link.cap_exceeded && st_r.active && st_r.step != 3'h1) begin
            st_nxt.cap = 1'b1;
        end
        if (start_in && !st_r.active) begin
            st_nxt.op = op_in;
            st_nxt.step = 3'h1;
            st_nxt.active = 1'b1;
            st_nxt.cap = 1'b0;
        end else if (go) begin
            st_nxt.step = st_r.step + 3'h1;
            if (st_r.step == 3'h2) begin
                st_nxt.wait_cnt = (st_r.op == SSM_OP_CMP) ? {4'h0, CMP_GAP_CNT} : 6'h00;
                if (st_r.op == SSM_OP_CMP) begin
                    st_nxt.step = 3'h3;
                end
            end
            if (st_r.step == 3'h3 && st_r.op == SSM_OP_CMP) begin
                st_nxt.active = 1'b0;
            end
            if (st_r.step == 3'h4) begin
                st_nxt.active = 1'b0;
            end
        end
        if (link.next_order_vld) begin
            st_nxt.next_order = link.next_order;
            st_nxt.next_order_vld = 1'b1;
        end
        // address select is registered so the memory side sees it change only on the edge
        st_nxt.addr_sel = (st_nxt.op == SSM_OP_CMP && st_nxt.step == 3'h3 && !st_nxt.cmp_sign) ? 3'h4
            : st_nxt.step;
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    // compare's last execute reads third address on minus sign, else fourth
    assign addr_sel_out = st_r.addr_sel;
    assign exec_pending_out = st_r.active;
    assign link.op = st_r.op;
    assign link.exec_sel = (st_r.op == SSM_OP_CMP && st_r.step == 3'h3) ? 3'h3 : st_r.step;
    assign link.exec_stb = go; // multiply store waits on busy
    assign link.mem_word = word_in;
    assign next_order_out = st_r.next_order;
    assign next_order_vld_out = st_r.next_order_vld;
    assign cap_exceeded_out = st_r.cap;
endmodule

// [testbench/ssm_monitor.sv]
`timescale 1ns/1ps
// watches the link between the dispatcher end and the arithmetic unit end
module ssm_monitor
    import ssm_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [1:0] op,
    input wire logic [2:0] exec_sel,
    input wire logic exec_stb,
    input wire logic [43:0] mem_word,
    input wire logic [43:0] store_word,
    input wire logic store_vld,
    input wire logic [43:0] recirc_word,
    input wire logic [43:0] next_order,
    input wire logic next_order_vld,
    input wire logic cap_exceeded,
    input wire logic cmp_vld,
    input wire logic busy
);
    logic [5:0] busy_cnt_r;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    // busy cycles are counted, since a repetition of 43 would be too slow to unroll
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_cnt_r <= 6'h00;
        end else begin
            busy_cnt_r <= busy ? busy_cnt_r + 6'h01 : 6'h00;
        end
    end
    // the steps of an order as seen on the link
    sequence s_mul_go;
        exec_stb && exec_sel == 3'h2 && op == SSM_OP_MUL;
    endsequence
    sequence s_cmp_diff;
        exec_stb && exec_sel == 3'h2 && op == SSM_OP_CMP;
    endsequence
    sequence s_store_go;
        exec_stb && exec_sel == 3'h3 && op != SSM_OP_CMP && !busy;
    endsequence
    sequence s_final;
        exec_stb && (exec_sel == 3'h4 || (op == SSM_OP_CMP && exec_sel == 3'h3));
    endsequence
    chk_mul_busy: assert property (s_mul_go |=> busy)
        else $error("multiply did not start");
    chk_mul_length: assert property ($fell(busy) |-> busy_cnt_r == MUL_CNT_INIT)
        else $error("multiply length wrong");
    chk_busy_no_cap: assert property (busy |-> !cap_exceeded)
        else $error("capacity flag during multiply");
    chk_busy_no_store: assert property (busy |-> !store_vld)
        else $error("store while multiply running");
    chk_store_step: assert property (s_store_go |=> store_vld)
        else $error("store missing after third execute");
    chk_cmp_quiet: assert property (exec_stb && op == SSM_OP_CMP |=> !store_vld)
        else $error("compare wrote memory");
    chk_cmp_gap: assert property (s_cmp_diff |=> (cmp_vld && !exec_stb) ##1 !exec_stb)
        else $error("compare result or spacing wrong");
    chk_next_word: assert property (s_final |=> next_order_vld && next_order == $past(mem_word))
        else $error("next order word wrong");
    chk_recirc_word: assert property (exec_stb && exec_sel == 3'h1 |=> recirc_word == $past(mem_word))
        else $error("first word not recirculated");
    chk_zero_plus: assert property (store_vld && store_word[42:0] == 43'h0 && !cap_exceeded |-> !store_word[43])
        else $error("computed zero stored with minus");
endmodule

// [testbench/serial_sub_compare_multiply_unit_test.sv]
`timescale 1ns/1ps
// runs whole orders through the dispatcher end and checks stored words
module serial_sub_compare_multiply_unit_test;
    import ssm_pkg::*;
    localparam logic [43:0] W3 = 44'h123_4567_89AB;
    localparam logic [43:0] W4 = 44'h0BC_DEF0_1234;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic start_in = 1'b0;
    logic [1:0] op_in = 2'h0;
    logic [43:0] mem [0:7];
    logic [2:0] addr_sel;
    logic [43:0] next_order;
    logic [43:0] st_w;
    logic next_vld;
    logic cap;
    logic pend;
    logic busy;
    int failures = 0;
    int checks_done = 0;
    int st_cnt = 0;
    logic timed_out = 1'b0;
    ssm_if link();
    ssm_unit u_ssm_unit(.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link), .busy_out(busy));
    ssm_disp u_ssm_disp(.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link), .start_in(start_in), .op_in(op_in),
        .word_in(mem[addr_sel]), .addr_sel_out(addr_sel), .exec_pending_out(pend), .next_order_out(next_order),
        .next_order_vld_out(next_vld), .cap_exceeded_out(cap));
    ssm_monitor u_ssm_monitor(.clk_in(clk_in), .rst_n_in(rst_n_in), .op(link.op), .exec_sel(link.exec_sel),
        .exec_stb(link.exec_stb), .mem_word(link.mem_word), .store_word(link.store_word),
        .store_vld(link.store_vld), .recirc_word(link.recirc_word), .next_order(link.next_order),
        .next_order_vld(link.next_order_vld), .cap_exceeded(link.cap_exceeded), .cmp_vld(link.cmp_vld),
        .busy(link.busy));
    // free running clock, 25 ns period
    initial forever #12.5 clk_in = ~clk_in;
    // the memory side keeps the last word the unit stored
    always @(posedge clk_in) begin
        if (link.store_vld === 1'b1) begin
            st_cnt++;
            st_w = link.store_word;
        end
    end
    task automatic check(input string name, input logic [43:0] exp, input logic [43:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // sign and magnitude word to a signed count of 2^-43 units; minus zero decodes as zero
    function automatic logic signed [44:0] val(input logic [43:0] w);
        logic signed [44:0] m;
        m = {2'b00, w[42:0]};
        return w[43] ? -m : m;
    endfunction
    // one order from start to next order word, expectations from the arithmetic
    task automatic run_order(input logic [1:0] op, input logic [43:0] a, input logic [43:0] b);
        logic signed [44:0] d;
        logic [44:0] mag;
        logic [85:0] p;
        logic [42:0] r;
        logic [43:0] exp_w;
        int n0;
        int k;
        int nb;
        // after a hang the remaining orders are skipped so the report comes quickly
        if (timed_out) begin
            return;
        end
        d = val(a) - val(b);
        mag = d < 0 ? -d : d;
        p = 86'(a[42:0]) * 86'(b[42:0]);
        r = 43'((p + (86'h1 << 42)) >> 43);
        exp_w = (op == SSM_OP_MUL) ? {(a[43] ^ b[43]) && (r != 43'h0), r} : {d < 0, mag[42:0]};
        mem[1] = a;
        mem[2] = b;
        n0 = st_cnt;
        @(negedge clk_in);
        start_in = 1'b1;
        op_in = op;
        @(negedge clk_in);
        start_in = 1'b0;
        check("pending after start", 44'h1, {43'h0, pend});
        k = 0;
        nb = 0;
        // busy is counted at every falling edge until the next order word arrives
        while (next_vld !== 1'b1 && k < 100) begin
            @(negedge clk_in);
            k++;
            if (busy === 1'b1) begin
                nb++;
            end
        end
        if (next_vld !== 1'b1) begin
            failures++;
            timed_out = 1'b1;
            $display("[ERR] next order wait expected 1 seen 0");
            return;
        end
        check("busy cycles", (op == SSM_OP_MUL) ? 44'(MUL_CYCLES) : 44'h0, 44'(nb));
        check("pending after order", 44'h0, {43'h0, pend});
        if (op == SSM_OP_CMP) begin
            check("compare next order", d < 0 ? W3 : W4, next_order);
            check("compare store count", 44'(n0), 44'(st_cnt));
        end else begin
            check("stored word", exp_w, st_w);
            check("store count", 44'(n0 + 1), 44'(st_cnt));
            check("next order", W4, next_order);
            check("capacity flag", {43'h0, op == SSM_OP_SUB && mag[43]}, {43'h0, cap});
        end
        @(negedge clk_in);
    endtask
    // reset, then back to back orders covering the awkward values
    initial begin
        foreach (mem[i]) mem[i] = 44'h000_0000_0000;
        mem[3] = W3;
        mem[4] = W4;
        repeat (5) @(negedge clk_in);
        check("flag in reset", 44'h000_0000_0000, {43'h0, cap});
        rst_n_in = 1'b1;
        run_order(SSM_OP_SUB, 44'h400_0000_0000, 44'h200_0000_0000);
        run_order(SSM_OP_SUB, 44'hE00_0000_0000, 44'h400_0000_0000);
        run_order(SSM_OP_SUB, 44'hC00_0000_0000, 44'h400_0000_0000);
        run_order(SSM_OP_SUB, 44'h800_0000_0000, 44'h000_0000_0000);
        run_order(SSM_OP_SUB, 44'h7FF_FFFF_FFFF, 44'hFFF_FFFF_FFFF);
        run_order(SSM_OP_CMP, 44'h200_0000_0000, 44'h400_0000_0000);
        run_order(SSM_OP_CMP, 44'h800_0000_0000, 44'h000_0000_0000);
        run_order(SSM_OP_CMP, 44'hC00_0000_0000, 44'h400_0000_0000);
        run_order(SSM_OP_MUL, 44'h400_0000_0000, 44'hC00_0000_0000);
        run_order(SSM_OP_MUL, 44'h7FF_FFFF_FFFF, 44'h7FF_FFFF_FFFF);
        run_order(SSM_OP_MUL, 44'h000_0000_0001, 44'h400_0000_0000);
        run_order(SSM_OP_MUL, 44'h000_0000_0001, 44'h800_0000_0001);
        // reset in the middle of a multiply must drop busy and the pending order
        mem[1] = 44'h7FF_FFFF_FFFF;
        mem[2] = 44'h7FF_FFFF_FFFF;
        @(negedge clk_in);
        start_in = 1'b1;
        op_in = SSM_OP_MUL;
        @(negedge clk_in);
        start_in = 1'b0;
        repeat (10) @(negedge clk_in);
        check("busy mid multiply", 44'h1, {43'h0, busy});
        rst_n_in = 1'b0;
        @(negedge clk_in);
        check("busy in reset", 44'h0, {43'h0, busy});
        check("pending in reset", 44'h0, {43'h0, pend});
        rst_n_in = 1'b1;
        run_order(SSM_OP_SUB, 44'h400_0000_0000, 44'h200_0000_0000);
        stop_test();
    end
endmodule
